// ==== rsd_pkg.sv ====
// Constants and types for the remote switch packet decoder
// Behaviour
// - Idle receiver starts only after the serial line goes low to high.
// - Capture whole packet, check framing and redundancy of every byte first.
// - A packet passing all checks drives its four bits onto the switch lines.
// - A failing packet is dropped, outputs untouched, search restarts.
// - Hold timer keeps outputs 131 ms; each valid packet restarts it.
// - Hold expiry forces all switch lines low and enters sleep.
// - Rate strap is sampled once as a static level after reset.
// - Encoder and decoder must run the same bit rate.
// - Switch line n follows encoder input line n.
// - Strap low selects 2400 bit/s, strap high 9600 bit/s.
package rsd_pkg;

  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BAUD_LO = 2400;
  localparam int unsigned BAUD_HI = 9600;
  localparam int unsigned HOLD_MS = 131;
  localparam int unsigned BIT_CYC_LO = CLK_HZ / BAUD_LO;
  localparam int unsigned BIT_CYC_HI = CLK_HZ / BAUD_HI;
  localparam int unsigned HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
  localparam logic [4:0] HUNT_BITS = 5'h10;
  localparam logic [7:0] SYNC_BYTE = 8'ha5;
  localparam logic [1:0] PKT_LAST_BYTE = 2'h2;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [3:0] LINES_RST = 4'h0;
  localparam logic [31:0] CNT_ZERO = 32'h0;

  // Packet: sync, data nibble with its complement, xor check
  typedef struct packed {
    logic [7:0] sync;
    logic [7:0] data;
    logic [7:0] check;
  } rsd_pkt_t;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'b000,
    ST_ARMED = 3'b001,
    ST_HUNT = 3'b010,
    ST_START = 3'b011,
    ST_DATA = 3'b100,
    ST_STOP = 3'b101,
    ST_CHECK = 3'b110
  } rsd_state_t;

  function automatic logic rsd_pkt_ok(input rsd_pkt_t p);
    rsd_pkt_ok = (p.sync == SYNC_BYTE) && (p.data[7:4] == ~p.data[3:0]) &&
                 (p.check == (p.sync ^ p.data));
  endfunction : rsd_pkt_ok

endpackage : rsd_pkg

// ==== rsd_decoder.sv ====
// Remote switch packet decoder top
`timescale 1ns/100ps
`default_nettype none
module rsd_decoder
  import rsd_pkg::*;
#(
  parameter int unsigned P_BIT_CYC_LO = BIT_CYC_LO,
  parameter int unsigned P_BIT_CYC_HI = BIT_CYC_HI,
  parameter int unsigned P_HOLD_CYC = HOLD_CYC
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_SERIAL_IN,
  input wire logic I_RATE_SEL,
  output logic [3:0] O_SWITCH_LINES,
  output logic O_SLEEP,
  output logic O_PKT_VALID
);

  rsd_state_t state_r;
  logic line_prev_r;
  logic strap_taken_r;
  logic rate_sel_r;
  logic [31:0] cnt_r;
  logic [31:0] bit_cyc;
  logic [31:0] half_cyc;
  logic [2:0] bit_idx_r;
  logic [1:0] byte_idx_r;
  logic [4:0] hunt_bits_r;
  logic [7:0] shreg_r;
  rsd_pkt_t pkt_r;
  logic pkt_good_nxt;
  logic [31:0] hold_r;
  logic tick;
  logic [31:0] bit_reload;
  logic [31:0] half_reload;
  logic rise_seen;
  logic fall_seen;
  logic hunt_done;
  logic wake_now;
  logic data_tick;
  logic stop_ok;
  logic timed_state;

  // Down-counter reload: a count of n spans exactly n cycles
  function automatic logic [31:0] cyc_reload(input logic [31:0] cycles);
    cyc_reload = cycles - 32'h1;
  endfunction : cyc_reload

  assign bit_cyc = rate_sel_r ? P_BIT_CYC_HI : P_BIT_CYC_LO;
  assign half_cyc = {1'b0, bit_cyc[31:1]};
  assign bit_reload = cyc_reload(bit_cyc);
  assign half_reload = cyc_reload(half_cyc);
  assign tick = (cnt_r == CNT_ZERO);
  assign rise_seen = I_SERIAL_IN && !line_prev_r;
  assign fall_seen = line_prev_r && !I_SERIAL_IN;
  assign hunt_done = (hunt_bits_r == HUNT_BITS);
  assign wake_now = (state_r == ST_ARMED) && rise_seen;
  assign data_tick = (state_r == ST_DATA) && tick;
  assign stop_ok = (state_r == ST_STOP) && tick && I_SERIAL_IN;
  assign timed_state = (state_r == ST_HUNT) || (state_r == ST_START) ||
                       (state_r == ST_DATA) || (state_r == ST_STOP);
  assign pkt_good_nxt = (state_r == ST_CHECK) && rsd_pkt_ok(pkt_r);

  // Strap caught once after release; rate stays fixed afterwards
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      strap_taken_r <= 1'b0;
      rate_sel_r <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      rate_sel_r <= I_RATE_SEL;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      line_prev_r <= 1'b0;
    end else begin
      line_prev_r <= I_SERIAL_IN;
    end
  end

  // Receive sequencer
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      state_r <= ST_SLEEP;
    end else begin
      unique case (state_r)
        ST_SLEEP: begin
          // Strap must settle before any reception
          if (strap_taken_r && !I_SERIAL_IN) begin
            state_r <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (rise_seen) begin
            state_r <= ST_HUNT;
          end
        end
        ST_HUNT: begin
          if (fall_seen) begin
            state_r <= ST_START;
          end else if (tick && hunt_done) begin
            // Bounded wait so a dead line falls back to sleep
            state_r <= ST_SLEEP;
          end
        end
        ST_START: begin
          if (tick) begin
            // High at mid start bit is noise, not a byte
            state_r <= I_SERIAL_IN ? ST_SLEEP : ST_DATA;
          end
        end
        ST_DATA: begin
          if (tick && (bit_idx_r == LAST_DATA_BIT)) begin
            state_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tick) begin
            if (!I_SERIAL_IN) begin
              state_r <= ST_SLEEP;
            end else if (byte_idx_r == PKT_LAST_BYTE) begin
              state_r <= ST_CHECK;
            end else begin
              state_r <= ST_HUNT;
            end
          end
        end
        ST_CHECK: begin
          // Good or bad, look for the next packet start
          state_r <= ST_SLEEP;
        end
        default: begin
          state_r <= ST_SLEEP;
        end
      endcase
    end
  end

  // Bit timer; reloading one short keeps sample points from drifting
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      cnt_r <= CNT_ZERO;
    end else if (wake_now) begin
      cnt_r <= bit_reload;
    end else if ((state_r == ST_HUNT) && fall_seen) begin
      cnt_r <= half_reload;
    end else if (tick && timed_state) begin
      cnt_r <= bit_reload;
    end else if (!tick) begin
      cnt_r <= cnt_r - 32'h1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      bit_idx_r <= 3'h0;
    end else if ((state_r == ST_START) && tick) begin
      bit_idx_r <= 3'h0;
    end else if (data_tick) begin
      bit_idx_r <= bit_idx_r + 3'h1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      byte_idx_r <= 2'h0;
    end else if (wake_now) begin
      byte_idx_r <= 2'h0;
    end else if (stop_ok) begin
      byte_idx_r <= byte_idx_r + 2'h1;
    end
  end

  // Gap counter between bytes, in bit times
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      hunt_bits_r <= 5'h0;
    end else if (wake_now || stop_ok) begin
      hunt_bits_r <= 5'h0;
    end else if ((state_r == ST_HUNT) && tick && !fall_seen && !hunt_done) begin
      hunt_bits_r <= hunt_bits_r + 5'h1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      shreg_r <= 8'h00;
    end else if (data_tick) begin
      shreg_r <= {I_SERIAL_IN, shreg_r[7:1]};
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      pkt_r <= '0;
    end else if (stop_ok) begin
      pkt_r <= {pkt_r[15:0], shreg_r};
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_PKT_VALID <= 1'b0;
    end else begin
      O_PKT_VALID <= pkt_good_nxt;
    end
  end

  // Output lines, hold timer and sleep flag
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_SWITCH_LINES <= LINES_RST;
      O_SLEEP <= 1'b1;
      hold_r <= CNT_ZERO;
    end else if (pkt_good_nxt) begin
      O_SWITCH_LINES <= pkt_r.data[3:0];
      O_SLEEP <= 1'b0;
      hold_r <= P_HOLD_CYC;
    end else if (hold_r != CNT_ZERO) begin
      hold_r <= hold_r - 32'h1;
      if (hold_r == 32'h1) begin
        // Lag is deliberate: lost packets must not chatter relays
        O_SWITCH_LINES <= LINES_RST;
        O_SLEEP <= 1'b1;
      end
    end
  end

endmodule : rsd_decoder
`default_nettype wire

// ==== rsd_properties.sv ====
// Port assertions for the switch decoder
`timescale 1ns/100ps
`default_nettype none
module rsd_props
  import rsd_pkg::*;
#(parameter int unsigned P_HOLD_CYC = HOLD_CYC) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_SERIAL_IN,
  input wire logic [3:0] O_SWITCH_LINES,
  input wire logic O_SLEEP,
  input wire logic O_PKT_VALID
);
  // Cycles since the last valid packet
  logic [31:0] age_r;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  always_ff @(posedge I_SYS_CLK)
    age_r <= (!I_RST_N || O_PKT_VALID) ? {31'h0, I_RST_N} : age_r + 32'h1;
  sequence s_low; !I_SERIAL_IN [*8]; endsequence
  property p_gap; O_PKT_VALID |=> !O_PKT_VALID [*8]; endproperty
  a_gap: assert property (p_gap) else $error("pulse");
  property p_low; s_low |-> !O_PKT_VALID; endproperty
  a_low: assert property (p_low) else $error("frame");
  property p_chg; $changed(O_SWITCH_LINES) |-> O_PKT_VALID || $rose(O_SLEEP); endproperty
  a_chg: assert property (p_chg) else $error("lines");
  property p_clr; O_SLEEP |-> O_SWITCH_LINES == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_wake; $fell(O_SLEEP) |-> O_PKT_VALID; endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_on; O_PKT_VALID |-> !O_SLEEP; endproperty
  a_on: assert property (p_on) else $error("awake");
  property p_exp; $rose(O_SLEEP) |-> age_r == P_HOLD_CYC; endproperty
  a_exp: assert property (p_exp) else $error("expiry");
  property p_hold; !O_SLEEP && !O_PKT_VALID |-> age_r < P_HOLD_CYC; endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule : rsd_props
bind rsd_decoder rsd_props #(.P_HOLD_CYC(P_HOLD_CYC)) rsd_props_inst (.*);
`default_nettype wire

// ==== rsd_enc.sv ====
// Behavioural switch encoder on the serial line
`timescale 1ns/100ps
`default_nettype none
module rsd_enc
  import rsd_pkg::*;
(
  input wire logic i_clk,
  output logic o_ser
);
  initial o_ser = 1'b0;
  // Bad flips a check bit; the packet is still finished
  task automatic send(input logic [3:0] d, input int bc, input bit bad);
    logic [30:0] f;
    f = {1'b1, SYNC_BYTE ^ {~d, d} ^ {7'h0, bad}, 2'h1, ~d, d, 2'h1, SYNC_BYTE, 2'h1};
    for (int i = 0; i < 31; i++) begin
      o_ser = f[i];
      repeat (bc) @(posedge i_clk);
      #1;
    end
    o_ser = 1'b0;
  endtask : send
endmodule : rsd_enc
`default_nettype wire

// ==== tb.sv ====
// Bench for the switch decoder
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic I_SYS_CLK = 1'b0, I_RST_N = 1'b0, I_RATE_SEL = 1'b0, ser, vld, slp, seen;
  logic [3:0] lines;
  int miscompares = 0, samples_checked = 0;
  rsd_decoder #(.P_BIT_CYC_LO(64), .P_BIT_CYC_HI(16), .P_HOLD_CYC(5000)) rsd_decoder_inst (
    .I_SYS_CLK, .I_RST_N, .I_SERIAL_IN(ser), .I_RATE_SEL,
    .O_SWITCH_LINES(lines), .O_SLEEP(slp), .O_PKT_VALID(vld));
  rsd_enc rsd_enc_inst (.i_clk(I_SYS_CLK), .o_ser(ser));
  initial forever #2 I_SYS_CLK = ~I_SYS_CLK;
  task automatic chk(input logic [3:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge I_SYS_CLK);
    #1;
  endtask : tick
  task automatic pkt(input logic [3:0] d, v, exp, input int bc, input bit bad);
    seen = 1'b0;
    fork
      rsd_enc_inst.send(d, bc, bad);
      repeat (33 * bc) begin
        tick(1);
        if (vld === 1'b1) seen = 1'b1;
      end
    join
    chk({3'h0, seen}, v);
    chk(lines, exp);
  endtask : pkt
  task automatic t_rates();
    for (int r = 0; r < 2; r++) begin
      I_RST_N = 1'b0;
      I_RATE_SEL = r[0];
      tick(3);
      I_RST_N = 1'b1;
      tick(3);
      pkt(4'h5, 4'h1, 4'h5, 64 >> 2 * r, 1'b0);
      pkt(4'ha, 4'h0, 4'h5, 64 >> 2 * r, 1'b1);
      pkt(4'ha, 4'h1, 4'ha, 64 >> 2 * r, 1'b0);
    end
  endtask : t_rates
  task automatic t_hold();
    I_RATE_SEL = 1'b0;
    pkt(4'h6, 4'h1, 4'h6, 16, 1'b0);
    chk({3'h0, slp}, 4'h0);
    tick(4800);
    chk(lines, 4'h6);
    tick(300);
    chk(lines, 4'h0);
    chk({3'h0, slp}, 4'h1);
  endtask : t_hold
  task automatic give_verdict();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    tick(40000);
    miscompares++;
    give_verdict();
  end
  initial begin
    t_rates();
    t_hold();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
